// ---- hdl/scm_misc_regs.sv ----
// system-configuration misc registers: clock output divider, power-on capture, brown-out, tick cal, wake edges
`timescale 1ns/1ps
module scm_misc_regs
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// register port
	input wire logic [31:0] busAddr,
	input wire logic [31:0] busWdata,
	input wire logic busWrite,
	input wire logic busRead,
	output logic [31:0] busRdata,
	// output clock
	input wire logic clkSrcTick,
	output logic clkOut,
	// general-purpose pins
	input wire logic [11:0] port0Pins,
	input wire logic [11:0] port1Pins,
	input wire logic [11:0] port2Pins,
	input wire logic [5:0] port3Pins,
	// brown-out detector
	input wire logic [3:0] bodIntTrip,
	input wire logic [3:0] bodRstTrip,
	output logic [1:0] brownoutResetLevel,
	output logic [1:0] brownoutInterruptLevel,
	output logic brownoutIrq,
	output logic brownoutReset,
	// tick timer and wake-up
	output logic [25:0] coreTickCalibration,
	output logic [39:0] wakeStart
);
	logic [41:0] pinMeta_q;
	logic [41:0] pinSync_q;
	logic [31:0] capLow_q;
	logic [9:0] capHigh_q;
	scm_pkg::scm_cap_state_t capState_q;
	logic [7:0] clkDiv_q;
	logic [1:0] rstLevel_q;
	logic [1:0] intLevel_q;
	logic rstEna_q;
	logic [3:0] intMeta_q;
	logic [3:0] intSync_q;
	logic [3:0] rstMeta_q;
	logic [3:0] rstSync_q;
	logic irq_q;
	logic bodRst_q;
	logic [25:0] tickCal_q;
	logic [31:0] edgeLow_q;
	logic [7:0] edgeHigh_q;
	logic [31:0] rdata_d;
	logic [31:0] rdata_q;
	logic clkOutInt;
	logic [39:0] wakeStartInt;
	logic [39:0] wakePins;
	logic [39:0] edgeAll;

	// pin synchronisers for the power-on capture
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pinMeta_q <= '0;
			pinSync_q <= '0;
		end
		else
		begin
			pinMeta_q <= {port3Pins, port2Pins, port1Pins, port0Pins};
			pinSync_q <= pinMeta_q;
		end
	end

	// capture sequence: wait for synchronised pins, then take them once
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			capState_q <= scm_pkg::CAP_SETTLE1;
		else
		begin
			case (capState_q)
				scm_pkg::CAP_SETTLE1: capState_q <= scm_pkg::CAP_SETTLE2;
				scm_pkg::CAP_SETTLE2: capState_q <= scm_pkg::CAP_TAKE;
				scm_pkg::CAP_TAKE: capState_q <= scm_pkg::CAP_DONE;
				scm_pkg::CAP_DONE: capState_q <= scm_pkg::CAP_DONE;
				default: capState_q <= scm_pkg::CAP_DONE;
			endcase
		end
	end

	// captured levels; no bus write path reaches them
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			capLow_q <= '0;
			capHigh_q <= '0;
		end
		else if (capState_q == scm_pkg::CAP_TAKE)
		begin
			capLow_q <= {pinSync_q[31:24], pinSync_q[23:12], pinSync_q[11:0]};
			capHigh_q <= pinSync_q[41:32];
		end
	end

	// output clock divider register
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			clkDiv_q <= scm_pkg::CLKOUT_DIV_RST;
		else if (busWrite && busAddr == scm_pkg::CLKOUT_DIV_ADDR)
			clkDiv_q <= busWdata[7:0];
	end

	scm_clkout_div u_clkout_div
	(
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.srcTick(clkSrcTick),
		.divValue(clkDiv_q),
		.clkOut(clkOutInt)
	);

	assign clkOut = clkOutInt;

	// brown-out control fields
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rstLevel_q <= scm_pkg::BOD_LEVEL_RST;
			intLevel_q <= scm_pkg::BOD_LEVEL_RST;
			rstEna_q <= 1'b0;
		end
		else if (busWrite && busAddr == scm_pkg::BOD_CTRL_ADDR)
		begin
			rstLevel_q <= busWdata[scm_pkg::BOD_RST_LEV_LSB +: 2];
			intLevel_q <= busWdata[scm_pkg::BOD_INT_LEV_LSB +: 2];
			rstEna_q <= busWdata[scm_pkg::BOD_RST_ENA_BIT];
		end
	end

	// detector comparator synchronisers
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			intMeta_q <= '0;
			intSync_q <= '0;
			rstMeta_q <= '0;
			rstSync_q <= '0;
		end
		else
		begin
			intMeta_q <= bodIntTrip;
			intSync_q <= intMeta_q;
			rstMeta_q <= bodRstTrip;
			rstSync_q <= rstMeta_q;
		end
	end

	// interrupt and forced reset requests
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			irq_q <= 1'b0;
			bodRst_q <= 1'b0;
		end
		else
		begin
			irq_q <= intSync_q[intLevel_q];
			bodRst_q <= rstEna_q & rstSync_q[rstLevel_q];
		end
	end

	assign brownoutResetLevel = rstLevel_q;
	assign brownoutInterruptLevel = intLevel_q;
	assign brownoutIrq = irq_q;
	assign brownoutReset = bodRst_q;

	// tick calibration
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			tickCal_q <= scm_pkg::TICK_CAL_RST;
		else if (busWrite && busAddr == scm_pkg::TICK_CAL_ADDR)
			tickCal_q <= busWdata[25:0];
	end

	assign coreTickCalibration = tickCal_q;

	// wake-up edge select registers
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			edgeLow_q <= scm_pkg::EDGE_LOW_RST;
			edgeHigh_q <= scm_pkg::EDGE_HIGH_RST;
		end
		else
		begin
			if (busWrite && busAddr == scm_pkg::EDGE_LOW_ADDR)
				edgeLow_q <= busWdata;
			if (busWrite && busAddr == scm_pkg::EDGE_HIGH_ADDR)
				edgeHigh_q <= busWdata[7:0];
		end
	end

	// wake line n is pin n in port order
	assign wakePins = {port3Pins[3:0], port2Pins[11:8], port2Pins[7:0], port1Pins, port0Pins};
	assign edgeAll = {edgeHigh_q, edgeLow_q};

	scm_wake_edge u_wake_edge
	(
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.wakePins(wakePins),
		.edgeSelect(edgeAll),
		.wakeStart(wakeStartInt)
	);

	assign wakeStart = wakeStartInt;

	// read mux; unmapped addresses read zero
	always_comb
	begin
		rdata_d = 32'h00000000;
		case (busAddr)
			scm_pkg::CLKOUT_DIV_ADDR: rdata_d = {24'h000000, clkDiv_q};
			scm_pkg::CAP_LOW_ADDR: rdata_d = capLow_q;
			scm_pkg::CAP_HIGH_ADDR: rdata_d = {22'h000000, capHigh_q};
			scm_pkg::BOD_CTRL_ADDR: rdata_d = {27'h0000000, rstEna_q, intLevel_q, rstLevel_q};
			scm_pkg::TICK_CAL_ADDR: rdata_d = {6'h00, tickCal_q};
			scm_pkg::EDGE_LOW_ADDR: rdata_d = edgeLow_q;
			scm_pkg::EDGE_HIGH_ADDR: rdata_d = {24'h000000, edgeHigh_q};
			default: rdata_d = 32'h00000000;
		endcase
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			rdata_q <= 32'h00000000;
		else if (busRead)
			rdata_q <= rdata_d;
		else
			rdata_q <= 32'h00000000;
	end

	assign busRdata = rdata_q;

	property p_cap_take;
		@(posedge ref_clk) disable iff (!reset_n)
		(capState_q == scm_pkg::CAP_TAKE) |=> (capLow_q[11:0] == $past(pinSync_q[11:0])
			&& capLow_q[31:24] == $past(pinSync_q[31:24]));
	endproperty
	a_cap_take: assert property (p_cap_take) else $error("low capture mapping wrong");

	property p_cap_high;
		@(posedge ref_clk) disable iff (!reset_n)
		(capState_q == scm_pkg::CAP_TAKE) |=> (capHigh_q == $past(pinSync_q[41:32]));
	endproperty
	a_cap_high: assert property (p_cap_high) else $error("high capture mapping wrong");

	property p_cap_ro;
		@(posedge ref_clk) disable iff (!reset_n)
		(capState_q == scm_pkg::CAP_DONE) |=> ($stable(capLow_q) && $stable(capHigh_q));
	endproperty
	a_cap_ro: assert property (p_cap_ro) else $error("captured levels changed after capture");

	property p_cap_once;
		@(posedge ref_clk) disable iff (!reset_n)
		$rose(reset_n) |-> ##[0:4] (capState_q == scm_pkg::CAP_DONE);
	endproperty
	a_cap_once: assert property (p_cap_once) else $error("power-on capture not taken");

	property p_rst_level;
		@(posedge ref_clk) disable iff (!reset_n)
		(busWrite && busAddr == scm_pkg::BOD_CTRL_ADDR) |=> (brownoutResetLevel == $past(busWdata[1:0]));
	endproperty
	a_rst_level: assert property (p_rst_level) else $error("reset level field not written");

	property p_int_level;
		@(posedge ref_clk) disable iff (!reset_n)
		(busWrite && busAddr == scm_pkg::BOD_CTRL_ADDR) |=> (brownoutInterruptLevel == $past(busWdata[3:2]));
	endproperty
	a_int_level: assert property (p_int_level) else $error("interrupt level field not written");

	property p_irq;
		@(posedge ref_clk) disable iff (!reset_n)
		(intSync_q[intLevel_q] && $stable(intLevel_q)) |=> brownoutIrq;
	endproperty
	a_irq: assert property (p_irq) else $error("brown-out interrupt missed");

	property p_rst_ena;
		@(posedge ref_clk) disable iff (!reset_n)
		(!rstEna_q) |=> !brownoutReset;
	endproperty
	a_rst_ena: assert property (p_rst_ena) else $error("forced reset while disabled");

	property p_tick_read;
		@(posedge ref_clk) disable iff (!reset_n)
		(busRead && busAddr == scm_pkg::TICK_CAL_ADDR) |=> (busRdata == {6'h00, $past(tickCal_q)});
	endproperty
	a_tick_read: assert property (p_tick_read) else $error("tick calibration readback wrong");

	property p_edge_write;
		@(posedge ref_clk) disable iff (!reset_n)
		(busWrite && busAddr == scm_pkg::EDGE_LOW_ADDR) |=> (edgeAll[31:0] == $past(busWdata));
	endproperty
	a_edge_write: assert property (p_edge_write) else $error("edge select low not written");

	property p_div_write;
		@(posedge ref_clk) disable iff (!reset_n)
		(busWrite && busAddr == scm_pkg::CLKOUT_DIV_ADDR) |=> (clkDiv_q == $past(busWdata[7:0]));
	endproperty
	a_div_write: assert property (p_div_write) else $error("output clock divider not written");

	property p_rst_fire;
		@(posedge ref_clk) disable iff (!reset_n)
		(rstEna_q && rstSync_q[rstLevel_q]) |=> brownoutReset;
	endproperty
	a_rst_fire: assert property (p_rst_fire) else $error("forced reset missed at selected level");

	c_irq: cover property (@(posedge ref_clk) disable iff (!reset_n) $rose(brownoutIrq));
	c_bod_rst: cover property (@(posedge ref_clk) disable iff (!reset_n) $rose(brownoutReset));
	c_clk_run: cover property (@(posedge ref_clk) disable iff (!reset_n) $rose(clkOut) ##[1:600] $fell(clkOut));
	c_wake: cover property (@(posedge ref_clk) disable iff (!reset_n) wakeStart[32]);

endmodule

// ---- hdl/scm_pkg.sv ----
// package: register map, field layout and reset values of the system-configuration misc registers
package scm_pkg;

	// register byte addresses
	localparam logic [31:0] CLKOUT_DIV_ADDR = 32'h400480E8;
	localparam logic [31:0] CAP_LOW_ADDR = 32'h40048100;
	localparam logic [31:0] CAP_HIGH_ADDR = 32'h40048104;
	localparam logic [31:0] BOD_CTRL_ADDR = 32'h40048150;
	localparam logic [31:0] TICK_CAL_ADDR = 32'h40048154;
	localparam logic [31:0] EDGE_LOW_ADDR = 32'h40048200;
	localparam logic [31:0] EDGE_HIGH_ADDR = 32'h40048210;

	// field widths and positions
	localparam int DIV_W = 8;
	localparam int PORT0_LSB = 0;
	localparam int PORT1_LSB = 12;
	localparam int PORT2_LSB = 24;
	localparam int PORT_PINS = 12;
	localparam int PORT2_LOW_PINS = 8;
	localparam int PORT3_PINS = 6;
	localparam int CAP_HIGH_W = 10;
	localparam int BOD_RST_LEV_LSB = 0;
	localparam int BOD_INT_LEV_LSB = 2;
	localparam int BOD_RST_ENA_BIT = 4;
	localparam int BOD_W = 5;
	localparam int TICK_CAL_W = 26;
	localparam int EDGE_HIGH_W = 8;
	localparam int WAKE_LINES = 40;

	// reset values
	localparam logic [7:0] CLKOUT_DIV_RST = 8'h00;
	localparam logic [1:0] BOD_LEVEL_RST = 2'h0;
	localparam logic [25:0] TICK_CAL_RST = 26'h0000004;
	localparam logic [31:0] EDGE_LOW_RST = 32'h00000000;
	localparam logic [7:0] EDGE_HIGH_RST = 8'h00;

	// power-on capture sequence, gray along the path
	typedef enum logic [1:0] {
		CAP_SETTLE1 = 2'b00,
		CAP_SETTLE2 = 2'b01,
		CAP_TAKE = 2'b11,
		CAP_DONE = 2'b10
	} scm_cap_state_t;

endpackage

// ---- hdl/scm_clkout_div.sv ----
// output clock divider: glitch-free divide of the source clock tick stream
`timescale 1ns/1ps
module scm_clkout_div
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// source and setting
	input wire logic srcTick,
	input wire logic [7:0] divValue,
	// divided output
	output logic clkOut
);
	logic [7:0] cnt_q;
	logic [7:0] divLat_q;
	logic clkOut_q;

	// new value taken only at a period boundary with the output low
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cnt_q <= 8'h01;
			divLat_q <= 8'h00;
			clkOut_q <= 1'b0;
		end
		else if (srcTick)
		begin
			if (cnt_q != 8'h01)
				cnt_q <= cnt_q - 8'h01;
			else if (clkOut_q)
			begin
				clkOut_q <= 1'b0;
				cnt_q <= divLat_q;
			end
			else
			begin
				divLat_q <= divValue;
				if (divValue != 8'h00)
				begin
					clkOut_q <= 1'b1;
					cnt_q <= divValue;
				end
			end
		end
	end

	assign clkOut = clkOut_q;

	property p_div_stop;
		@(posedge ref_clk) disable iff (!reset_n)
		(divValue == 8'h00 && !clkOut_q) |=> !clkOut_q;
	endproperty
	a_div_stop: assert property (p_div_stop) else $error("output clock runs with divider zero");

	property p_no_runt;
		@(posedge ref_clk) disable iff (!reset_n)
		(clkOut_q && !(srcTick && cnt_q == 8'h01)) |=> clkOut_q;
	endproperty
	a_no_runt: assert property (p_no_runt) else $error("output clock high phase cut short");

endmodule

// ---- hdl/scm_wake_edge.sv ----
// wake-up edge detection: per pin synchroniser and selectable edge detector
`timescale 1ns/1ps
module scm_wake_edge
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// pins and edge choice
	input wire logic [39:0] wakePins,
	input wire logic [39:0] edgeSelect,
	// one-cycle start pulses
	output logic [39:0] wakeStart
);
	logic [39:0] meta_q;
	logic [39:0] sync_q;
	logic [39:0] prev_q;
	logic [39:0] start_q;

	genvar i;
	generate
		for (i = 0; i < scm_pkg::WAKE_LINES; i++)
		begin : g_line
			always_ff @(posedge ref_clk or negedge reset_n)
			begin
				if (!reset_n)
				begin
					meta_q[i] <= 1'b0;
					sync_q[i] <= 1'b0;
					prev_q[i] <= 1'b0;
					start_q[i] <= 1'b0;
				end
				else
				begin
					meta_q[i] <= wakePins[i];
					sync_q[i] <= meta_q[i];
					prev_q[i] <= sync_q[i];
					// 0 selects falling, 1 selects rising
					start_q[i] <= edgeSelect[i] ? (sync_q[i] & ~prev_q[i]) : (~sync_q[i] & prev_q[i]);
				end
			end
		end
	endgenerate

	assign wakeStart = start_q;

	property p_rise_start;
		@(posedge ref_clk) disable iff (!reset_n)
		(edgeSelect[0] && sync_q[0] && !prev_q[0]) |=> wakeStart[0];
	endproperty
	a_rise_start: assert property (p_rise_start) else $error("rising edge missed on line 0");

	property p_fall_start;
		@(posedge ref_clk) disable iff (!reset_n)
		(!edgeSelect[39] && !sync_q[39] && prev_q[39]) |=> wakeStart[39];
	endproperty
	a_fall_start: assert property (p_fall_start) else $error("falling edge missed on line 39");

endmodule

// ---- verif/sysconfig_misc_registers_tb_top.sv ----
// self-checking testbench for the system-configuration misc registers
`timescale 1ns/1ps
module sysconfig_misc_registers_tb_top;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [31:0] busAddr = 32'h0;
	logic [31:0] busWdata = 32'h0;
	logic busWrite = 1'b0;
	logic busRead = 1'b0;
	logic [31:0] busRdata;
	logic clkSrcTick = 1'b0;
	logic tickSlow = 1'b0;
	logic tickPh = 1'b0;
	logic clkOut;
	logic [41:0] pinsV = {6'h2B, 12'h9E7, 12'h3C1, 12'hA5C};
	logic [3:0] bodIntTrip = 4'h0;
	logic [3:0] bodRstTrip = 4'h0;
	logic [1:0] brownoutResetLevel;
	logic [1:0] brownoutInterruptLevel;
	logic brownoutIrq;
	logic brownoutReset;
	logic [25:0] coreTickCalibration;
	logic [39:0] wakeStart;
	int nErrors = 0;
	int cmpCount = 0;

	initial
	begin
		forever #25 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk)
	begin
		tickPh <= ~tickPh;
		clkSrcTick <= tickSlow ? tickPh : 1'b1;
	end

	scm_misc_regs u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .busAddr(busAddr), .busWdata(busWdata),
		.busWrite(busWrite), .busRead(busRead), .busRdata(busRdata), .clkSrcTick(clkSrcTick), .clkOut(clkOut),
		.port0Pins(pinsV[11:0]), .port1Pins(pinsV[23:12]), .port2Pins(pinsV[35:24]), .port3Pins(pinsV[41:36]),
		.bodIntTrip(bodIntTrip), .bodRstTrip(bodRstTrip), .brownoutResetLevel(brownoutResetLevel),
		.brownoutInterruptLevel(brownoutInterruptLevel), .brownoutIrq(brownoutIrq), .brownoutReset(brownoutReset),
		.coreTickCalibration(coreTickCalibration), .wakeStart(wakeStart));

	task automatic report_and_stop();
		$display("errors %0d comparisons %0d", nErrors, cmpCount);
		if (nErrors == 0 && cmpCount > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
		cmpCount++;
		if (seen !== exp)
		begin
			nErrors++;
			$display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		busWrite <= 1'b1;
		busAddr <= a;
		busWdata <= d;
		@(posedge ref_clk);
		busWrite <= 1'b0;
	endtask

	task automatic rdChk(input logic [31:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		busRead <= 1'b1;
		busAddr <= a;
		@(posedge ref_clk);
		busRead <= 1'b0;
		#1;
		chk({8'h00, busRdata}, {8'h00, exp});
	endtask

	task automatic t_reset();
		rdChk(scm_pkg::CLKOUT_DIV_ADDR, 32'h00000000);
		rdChk(scm_pkg::BOD_CTRL_ADDR, 32'h00000000);
		rdChk(scm_pkg::TICK_CAL_ADDR, 32'h00000004);
		rdChk(scm_pkg::EDGE_LOW_ADDR, 32'h00000000);
		rdChk(scm_pkg::EDGE_HIGH_ADDR, 32'h00000000);
		wr(32'h40048108, 32'hFFFFFFFF);
		rdChk(32'h40048108, 32'h00000000);
	endtask

	task automatic t_capture();
		rdChk(scm_pkg::CAP_LOW_ADDR, 32'hE73C1A5C);
		rdChk(scm_pkg::CAP_HIGH_ADDR, 32'h000002B9);
		wr(scm_pkg::CAP_LOW_ADDR, 32'h00000000);
		wr(scm_pkg::CAP_HIGH_ADDR, 32'hFFFFFFFF);
		@(posedge ref_clk);
		pinsV <= ~pinsV;
		cyc(6);
		rdChk(scm_pkg::CAP_LOW_ADDR, 32'hE73C1A5C);
		rdChk(scm_pkg::CAP_HIGH_ADDR, 32'h000002B9);
	endtask

	task automatic t_regs();
		wr(scm_pkg::CLKOUT_DIV_ADDR, 32'hFFFFFFFF);
		rdChk(scm_pkg::CLKOUT_DIV_ADDR, 32'h000000FF);
		wr(scm_pkg::BOD_CTRL_ADDR, 32'hFFFFFFFF);
		rdChk(scm_pkg::BOD_CTRL_ADDR, 32'h0000001F);
		chk({36'h0, brownoutResetLevel, brownoutInterruptLevel}, 40'hF);
		wr(scm_pkg::TICK_CAL_ADDR, 32'hFFFFFFFF);
		rdChk(scm_pkg::TICK_CAL_ADDR, 32'h03FFFFFF);
		chk({14'h0, coreTickCalibration}, 40'h03FFFFFF);
		wr(scm_pkg::EDGE_LOW_ADDR, 32'hA5A55A5A);
		rdChk(scm_pkg::EDGE_LOW_ADDR, 32'hA5A55A5A);
		wr(scm_pkg::EDGE_HIGH_ADDR, 32'hFFFFFFFF);
		rdChk(scm_pkg::EDGE_HIGH_ADDR, 32'h000000FF);
		wr(scm_pkg::CLKOUT_DIV_ADDR, 32'h0);
		wr(scm_pkg::BOD_CTRL_ADDR, 32'h0);
		wr(scm_pkg::TICK_CAL_ADDR, 32'h4);
	endtask

	task automatic t_brownout();
		logic [1:0] l;
		for (int i = 0; i < 4; i++)
		begin
			l = i[1:0];
			wr(scm_pkg::BOD_CTRL_ADDR, {27'h0, 1'b0, l, l});
			bodIntTrip <= 4'h1 << l;
			bodRstTrip <= 4'hF;
			cyc(5);
			chk({39'h0, brownoutIrq}, 40'h1);
			chk({39'h0, brownoutReset}, 40'h0);
			chk({36'h0, brownoutResetLevel, brownoutInterruptLevel}, {36'h0, l, l});
			wr(scm_pkg::BOD_CTRL_ADDR, {27'h0, 1'b1, l, l});
			bodIntTrip <= ~(4'h1 << l);
			bodRstTrip <= ~(4'h1 << l);
			cyc(5);
			chk({39'h0, brownoutIrq}, 40'h0);
			chk({39'h0, brownoutReset}, 40'h0);
			@(posedge ref_clk);
			bodRstTrip <= 4'h1 << l;
			cyc(5);
			chk({39'h0, brownoutReset}, 40'h1);
		end
		bodIntTrip <= 4'h0;
		bodRstTrip <= 4'h0;
		wr(scm_pkg::BOD_CTRL_ADDR, 32'h0);
	endtask

	task automatic setPin(input int n, input logic v);
		@(posedge ref_clk);
		pinsV[n] <= v;
	endtask

	task automatic watch(input int n, input int exp);
		int hits;
		int oth;
		hits = 0;
		oth = 0;
		repeat (10)
		begin
			cyc(1);
			if (wakeStart[n] === 1'b1)
				hits++;
			if ((wakeStart & ~(40'h1 << n)) !== 40'h0)
				oth++;
		end
		chk(40'(hits), 40'(exp));
		chk(40'(oth), 40'h0);
	endtask

	task automatic t_wake();
		int lines[5] = '{0, 17, 31, 32, 39};
		logic [39:0] sel;
		foreach (lines[k])
		begin
			sel = 40'h1 << lines[k];
			wr(scm_pkg::EDGE_LOW_ADDR, sel[31:0]);
			wr(scm_pkg::EDGE_HIGH_ADDR, {24'h0, sel[39:32]});
			setPin(lines[k], 1'b0);
			cyc(10);
			setPin(lines[k], 1'b1);
			watch(lines[k], 1);
			setPin(lines[k], 1'b0);
			watch(lines[k], 0);
			wr(scm_pkg::EDGE_LOW_ADDR, 32'h0);
			wr(scm_pkg::EDGE_HIGH_ADDR, 32'h0);
			setPin(lines[k], 1'b1);
			watch(lines[k], 0);
			setPin(lines[k], 1'b0);
			watch(lines[k], 1);
		end
	endtask

	task automatic waitLv(input logic v);
		for (int i = 0; i < 1200 && clkOut !== v; i++)
			cyc(1);
	endtask

	task automatic runLen(input logic v, output int c);
		c = 0;
		while (clkOut === v && c < 1200)
		begin
			c++;
			cyc(1);
		end
	endtask

	task automatic t_clk();
		int divs[3] = '{2, 255, 3};
		int hi;
		int lo;
		foreach (divs[k])
		begin
			@(posedge ref_clk);
			tickSlow <= (k == 2);
			wr(scm_pkg::CLKOUT_DIV_ADDR, divs[k]);
			waitLv(1'b1);
			waitLv(1'b0);
			waitLv(1'b1);
			runLen(1'b1, hi);
			runLen(1'b0, lo);
			chk(40'(hi), 40'(divs[k] * (k == 2 ? 2 : 1)));
			chk(40'(lo), 40'(divs[k] * (k == 2 ? 2 : 1)));
		end
		wr(scm_pkg::CLKOUT_DIV_ADDR, 32'h0);
		cyc(20);
		hi = 0;
		repeat (20)
		begin
			cyc(1);
			if (clkOut !== 1'b0)
				hi++;
		end
		chk(40'(hi), 40'h0);
	endtask

	initial
	begin
		repeat (8) @(posedge ref_clk);
		#1;
		chk({14'h0, coreTickCalibration}, 40'h4);
		chk({38'h0, brownoutIrq, brownoutReset}, 40'h0);
		repeat (8) @(posedge ref_clk);
		reset_n <= 1'b1;
		cyc(6);
		chk({39'h0, clkOut}, 40'h0);
		t_reset();
		t_capture();
		t_regs();
		t_brownout();
		t_wake();
		t_clk();
		report_and_stop();
	end

	initial
	begin
		repeat (40000) @(posedge ref_clk);
		nErrors++;
		report_and_stop();
	end
endmodule
